//--- hw/drive_select_status_options.sv
`timescale 1ns/1ps
`default_nettype none

module drive_select_status_options #(
    parameter int REV_MIN = drive_opts_pkg::REV_MIN_CYC,
    parameter int REV_MAX = drive_opts_pkg::REV_MAX_CYC
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host interface lines, active low.
    input wire logic [3:0] sel_n,
    input wire logic motor_on_request_n,
    input wire logic change_reset_n,
    input wire logic step_n,
    input wire logic in_use_n,
    // Drive sensors.
    input wire logic cartridge_present,
    input wire logic power_good,
    input wire logic index_pulse,
    // Status to host and drive actuators.
    output logic ready_n,
    output logic status_n,
    output logic motor_run,
    output logic lamp_on
);

    typedef struct packed {
        logic [1:0] sel_src;
        drive_opts_pkg::spin_src_t spin_src;
        logic clr_by_step;
        logic status_presence;
        logic lamp_host;
        drive_opts_pkg::motor_state_t mstate;
        logic change_latch;
        logic step_n_prev;
        logic ready_n;
        logic status_n;
        logic lamp_on;
        logic motor_run;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic up_to_speed;
    logic selected;
    logic spin_want;

    // Picks one active-low line of four and returns it as active high.
    function automatic logic line_active(input logic [3:0] lines_n, input logic [1:0] idx);
        line_active = !lines_n[idx];
    endfunction

    // Only the configured select line addresses this drive.
    assign selected = line_active(sel_n, s_reg.sel_src);

    // Motor source decode; the select-line sources let drives spin up one after another.
    always_comb begin
        case (s_reg.spin_src)
            drive_opts_pkg::SPIN_REQUEST: spin_want = !motor_on_request_n;
            drive_opts_pkg::SPIN_SEL2: spin_want = line_active(sel_n, 2'h2);
            drive_opts_pkg::SPIN_SEL3: spin_want = line_active(sel_n, 2'h3);
            drive_opts_pkg::SPIN_SEL0: spin_want = line_active(sel_n, 2'h0);
            default: spin_want = 1'b0;
        endcase
    end

    // Index revolutions decide when the spindle counts as up to speed.
    rev_monitor #(
        .REV_MIN(REV_MIN),
        .REV_MAX(REV_MAX),
        .REVS(drive_opts_pkg::REVS_NEEDED)
    ) u_rev (
        .pclk(pclk),
        .presetn(presetn),
        .enable(s_reg.mstate != drive_opts_pkg::M_IDLE),
        .index_pulse(index_pulse),
        .up_to_speed(up_to_speed)
    );

    // Next-state logic for the whole block.
    always_comb begin
        logic step_edge;
        logic clear_fire;
        logic rd_cfg;
        logic rd_st;
        step_edge = 1'b0;
        clear_fire = 1'b0;
        rd_cfg = 1'b0;
        rd_st = 1'b0;
        s_next = s_reg;
        s_next.step_n_prev = step_n;

        // Motor sequence: spin up on request, run once the index shows full speed.
        case (s_reg.mstate)
            drive_opts_pkg::M_IDLE: begin
                if (spin_want) begin
                    s_next.mstate = drive_opts_pkg::M_SPINUP;
                end
            end
            drive_opts_pkg::M_SPINUP: begin
                if (!spin_want) begin
                    s_next.mstate = drive_opts_pkg::M_IDLE;
                end else if (up_to_speed) begin
                    s_next.mstate = drive_opts_pkg::M_RUN;
                end
            end
            drive_opts_pkg::M_RUN: begin
                if (!spin_want) begin
                    s_next.mstate = drive_opts_pkg::M_IDLE;
                end else if (!up_to_speed) begin
                    s_next.mstate = drive_opts_pkg::M_SPINUP;
                end
            end
            default: s_next.mstate = drive_opts_pkg::M_IDLE;
        endcase

        // The motor output is its own flop so it leaves the block without any gate after it.
        s_next.motor_run = s_next.mstate != drive_opts_pkg::M_IDLE;

        // Ready only for a present, powered, spinning medium seen on the index.
        s_next.ready_n = !(selected && cartridge_present && power_good && up_to_speed
            && s_reg.mstate == drive_opts_pkg::M_RUN);

        // Change latch: the clear source follows the strap, and a set wins over it.
        step_edge = s_reg.step_n_prev && !step_n;
        clear_fire = s_reg.clr_by_step ? step_edge : !change_reset_n;
        if (clear_fire) begin
            s_next.change_latch = 1'b0;
        end
        if (!selected && !cartridge_present) begin
            s_next.change_latch = 1'b1;
        end

        // Shared status line, driven only for the addressed drive.
        if (s_reg.status_presence) begin
            s_next.status_n = !(selected && cartridge_present);
        end else begin
            s_next.status_n = !(selected && s_next.change_latch);
        end

        // Lamp source.
        s_next.lamp_on = s_reg.lamp_host ? !in_use_n : selected;

        // APB: the setup cycle prepares the answer so the access cycle has no wait.
        rd_cfg = paddr == drive_opts_pkg::ADDR_CONFIG;
        rd_st = paddr == drive_opts_pkg::ADDR_STATUS;
        s_next.pready = psel && !penable;
        s_next.pslverr = psel && !penable && !rd_cfg && !rd_st;
        if (psel && !penable) begin
            s_next.prdata = 32'h0;
            if (rd_cfg) begin
                s_next.prdata[drive_opts_pkg::CFG_SEL_LSB +: 2] = s_reg.sel_src;
                s_next.prdata[drive_opts_pkg::CFG_SPIN_LSB +: 2] = s_reg.spin_src;
                s_next.prdata[drive_opts_pkg::CFG_CLR_STEP_BIT] = s_reg.clr_by_step;
                s_next.prdata[drive_opts_pkg::CFG_PRESENCE_BIT] = s_reg.status_presence;
                s_next.prdata[drive_opts_pkg::CFG_LAMP_HOST_BIT] = s_reg.lamp_host;
            end else if (rd_st) begin
                s_next.prdata[drive_opts_pkg::ST_READY_BIT] = !s_reg.ready_n;
                s_next.prdata[drive_opts_pkg::ST_CHANGE_BIT] = s_reg.change_latch;
                s_next.prdata[drive_opts_pkg::ST_PRESENT_BIT] = cartridge_present;
                s_next.prdata[drive_opts_pkg::ST_MOTOR_BIT] =
                    s_reg.mstate != drive_opts_pkg::M_IDLE;
                s_next.prdata[drive_opts_pkg::ST_LAMP_BIT] = s_reg.lamp_on;
                s_next.prdata[drive_opts_pkg::ST_SELECTED_BIT] = selected;
                s_next.prdata[drive_opts_pkg::ST_SPEED_BIT] = up_to_speed;
                s_next.prdata[drive_opts_pkg::ST_MSTATE_LSB +: 3] = s_reg.mstate;
            end
        end

        // Straps are written by software; they are meant to change only while idle.
        if (psel && penable && s_reg.pready && pwrite && rd_cfg) begin
            s_next.sel_src = pwdata[drive_opts_pkg::CFG_SEL_LSB +: 2];
            s_next.spin_src = drive_opts_pkg::spin_src_t'(
                pwdata[drive_opts_pkg::CFG_SPIN_LSB +: 2]);
            s_next.clr_by_step = pwdata[drive_opts_pkg::CFG_CLR_STEP_BIT];
            s_next.status_presence = pwdata[drive_opts_pkg::CFG_PRESENCE_BIT];
            s_next.lamp_host = pwdata[drive_opts_pkg::CFG_LAMP_HOST_BIT];
        end
    end

    // State register; active-low outputs idle high-inactive after reset, the others low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.sel_src <= drive_opts_pkg::SEL_RESET;
            s_reg.spin_src <= drive_opts_pkg::SPIN_RESET;
            s_reg.clr_by_step <= drive_opts_pkg::CLR_STEP_RESET;
            s_reg.status_presence <= drive_opts_pkg::PRESENCE_RESET;
            s_reg.lamp_host <= drive_opts_pkg::LAMP_HOST_RESET;
            s_reg.mstate <= drive_opts_pkg::M_IDLE;
            s_reg.step_n_prev <= 1'b1;
            s_reg.ready_n <= 1'b1;
            s_reg.status_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // All outputs come straight from the state register.
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign ready_n = s_reg.ready_n;
    assign status_n = s_reg.status_n;
    assign motor_run = s_reg.motor_run;
    assign lamp_on = s_reg.lamp_on;

    // Checks on the block's own behaviour.
    sequence setup_phase;
        psel && !penable;
    endsequence

    sequence step_falls;
        step_n ##1 !step_n;
    endsequence

    a_apb_zero_wait: assert property (@(posedge pclk) disable iff (!presetn)
        setup_phase |=> pready && !$past(penable))
        else $error("APB answer not ready in the access cycle");

    a_ready_cause: assert property (@(posedge pclk) disable iff (!presetn)
        !ready_n |-> $past(cartridge_present && power_good && up_to_speed && selected))
        else $error("Ready asserted without cartridge, power and speed");

    a_ready_absent: assert property (@(posedge pclk) disable iff (!presetn)
        !cartridge_present |=> ready_n)
        else $error("Ready asserted with no cartridge");

    a_motor_request: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.spin_src == drive_opts_pkg::SPIN_REQUEST) ##0 $stable(s_reg.spin_src)
        |-> ##1 (motor_run || $past(motor_on_request_n)))
        else $error("Motor did not follow the request line");

    a_motor_sel_two: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.spin_src == drive_opts_pkg::SPIN_SEL2 && sel_n[2] && !psel) |=> !motor_run)
        else $error("Motor running without select 2");

    a_motor_sel_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.spin_src == drive_opts_pkg::SPIN_SEL0 && !sel_n[0] && !psel) |=> motor_run)
        else $error("Motor not started by select 0");

    a_change_set: assert property (@(posedge pclk) disable iff (!presetn)
        (!selected && !cartridge_present) |=> s_reg.change_latch)
        else $error("Change latch not set by removal while deselected");

    a_change_reset_line: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_reg.clr_by_step && !change_reset_n && (selected || cartridge_present))
        |=> !s_reg.change_latch)
        else $error("Change latch not cleared by reset line");

    a_change_by_step: assert property (@(posedge pclk) disable iff (!presetn)
        (step_falls ##0 (s_reg.clr_by_step && (selected || cartridge_present) && !psel))
        |=> !s_reg.change_latch)
        else $error("Change latch not cleared by step");

    // Without its clear source the latch must keep a pending change.
    a_change_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.change_latch && !s_reg.clr_by_step && change_reset_n) |=> s_reg.change_latch)
        else $error("Change latch dropped without a clear");

    // A drive that is not addressed keeps both shared lines released.
    a_desel_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !selected |=> (ready_n && status_n))
        else $error("Deselected drive drives ready or status");

    a_motor_sel_three: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.spin_src == drive_opts_pkg::SPIN_SEL3 && !sel_n[3] && !psel) |=> motor_run)
        else $error("Motor not started by select 3");

    a_status_presence: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.status_presence && selected && cartridge_present && !psel) |=> !status_n)
        else $error("Disk present status missing");

    a_lamp_select: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_reg.lamp_host && !psel) |=> lamp_on == $past(selected))
        else $error("Lamp does not follow select");

    a_lamp_host: assert property (@(posedge pclk) disable iff (!presetn)
        (s_reg.lamp_host && !psel) |=> lamp_on == !$past(in_use_n))
        else $error("Lamp does not follow host in-use line");

endmodule

`default_nettype wire

//--- hw/drive_opts_pkg.sv
package drive_opts_pkg;

    // Register byte addresses on the APB port.
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    // Configuration register field positions.
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_SPIN_LSB = 2;
    localparam int CFG_CLR_STEP_BIT = 4;
    localparam int CFG_PRESENCE_BIT = 5;
    localparam int CFG_LAMP_HOST_BIT = 6;

    // Status register field positions.
    localparam int ST_READY_BIT = 0;
    localparam int ST_CHANGE_BIT = 1;
    localparam int ST_PRESENT_BIT = 2;
    localparam int ST_MOTOR_BIT = 3;
    localparam int ST_LAMP_BIT = 4;
    localparam int ST_SELECTED_BIT = 5;
    localparam int ST_SPEED_BIT = 6;
    localparam int ST_MSTATE_LSB = 7;

    // Motor control sources.
    typedef enum logic [1:0] {
        SPIN_REQUEST = 2'h0,
        SPIN_SEL2 = 2'h1,
        SPIN_SEL3 = 2'h2,
        SPIN_SEL0 = 2'h3
    } spin_src_t;

    // Spindle motor states, one-hot.
    typedef enum logic [2:0] {
        M_IDLE = 3'h1,
        M_SPINUP = 3'h2,
        M_RUN = 3'h4
    } motor_state_t;

    // Reset values of the configuration fields: select line 0, motor from request,
    // change cleared by the reset line, change status routed, lamp follows select.
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam spin_src_t SPIN_RESET = SPIN_REQUEST;
    localparam logic CLR_STEP_RESET = 1'b0;
    localparam logic PRESENCE_RESET = 1'b0;
    localparam logic LAMP_HOST_RESET = 1'b0;

    // Index timing for the speed check.
    localparam int CLK_MHZ = 250;
    localparam int REV_MAX_US = 250000;
    localparam int REV_MIN_US = 150000;
    localparam int REV_MAX_CYC = REV_MAX_US * CLK_MHZ;
    localparam int REV_MIN_CYC = REV_MIN_US * CLK_MHZ;
    localparam int REVS_NEEDED = 2;

endpackage

//--- hw/rev_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module rev_monitor #(
    parameter int REV_MIN = drive_opts_pkg::REV_MIN_CYC,
    parameter int REV_MAX = drive_opts_pkg::REV_MAX_CYC,
    parameter int REVS = drive_opts_pkg::REVS_NEEDED,
    parameter int CW = $clog2(REV_MAX + 2)
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Motor and index sensor.
    input wire logic enable,
    input wire logic index_pulse,
    // Speed result.
    output logic up_to_speed
);

    typedef struct packed {
        logic [CW-1:0] period;
        logic [3:0] good;
        logic index_prev;
        logic speed;
    } mon_t;

    mon_t m_reg;
    mon_t m_next;

    // Each index edge closes one revolution; only periods inside the window count as good.
    always_comb begin
        m_next = m_reg;
        m_next.index_prev = index_pulse;
        if (!enable) begin
            m_next = '0;
            m_next.index_prev = index_pulse;
        end else if (index_pulse && !m_reg.index_prev) begin
            m_next.period = '0;
            if (m_reg.period >= CW'(REV_MIN) && m_reg.period <= CW'(REV_MAX)) begin
                if (m_reg.good != 4'(REVS)) begin
                    m_next.good = m_reg.good + 4'h1;
                end
            end else begin
                m_next.good = '0;
            end
        end else if (m_reg.period > CW'(REV_MAX)) begin
            // A stalled or missing medium drops the speed flag at once.
            m_next.good = '0;
        end else begin
            m_next.period = m_reg.period + CW'(1);
        end
        m_next.speed = enable && (m_next.good == 4'(REVS));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_reg <= '0;
        end else begin
            m_reg <= m_next;
        end
    end

    assign up_to_speed = m_reg.speed;

endmodule

`default_nettype wire

//--- sim/host_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_ctrl_model (
    // Clock.
    input wire logic pclk,
    // Host lines, active low.
    output logic [3:0] sel_n,
    output logic motor_on_request_n,
    output logic change_reset_n,
    output logic step_n,
    output logic in_use_n
);
    // Every line idles high, as the pull-ups on a daisy chain leave it.
    initial begin
        sel_n = 4'hf;
        motor_on_request_n = 1'b1;
        change_reset_n = 1'b1;
        step_n = 1'b1;
        in_use_n = 1'b1;
    end

    // Drive one select line low, or none when idx is above 3.
    task automatic select(input int idx);
        @(posedge pclk);
        sel_n <= (idx > 3) ? 4'hf : ~(4'h1 << idx);
    endtask

    // Raise or drop the motor request.
    task automatic motor(input logic on);
        @(posedge pclk);
        motor_on_request_n <= ~on;
    endtask

    // Raise or drop the in-use line.
    task automatic in_use(input logic on);
        @(posedge pclk);
        in_use_n <= ~on;
    endtask

    // Two-cycle low pulse on the change reset line.
    task automatic pulse_reset();
        @(posedge pclk);
        change_reset_n <= 1'b0;
        repeat (2) @(posedge pclk);
        change_reset_n <= 1'b1;
    endtask

    // Two-cycle low pulse on step; the drive acts on its falling edge.
    task automatic pulse_step();
        @(posedge pclk);
        step_n <= 1'b0;
        repeat (2) @(posedge pclk);
        step_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

//--- sim/test_drive_select_status_options.sv
`timescale 1ns/1ps
`default_nettype none

module test_drive_select_status_options;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] sel_n;
    logic motor_on_request_n, change_reset_n, step_n, in_use_n;
    logic cartridge_present, power_good, index_pulse;
    logic ready_n, status_n, motor_run, lamp_on;
    logic spin_on;
    int num_errors, checked, icnt;

    host_ctrl_model i_host (.pclk(pclk), .sel_n(sel_n), .motor_on_request_n(motor_on_request_n),
        .change_reset_n(change_reset_n), .step_n(step_n), .in_use_n(in_use_n));

    drive_select_status_options #(.REV_MIN(4), .REV_MAX(20)) i_drive_select_status_options (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sel_n(sel_n), .motor_on_request_n(motor_on_request_n), .change_reset_n(change_reset_n),
        .step_n(step_n), .in_use_n(in_use_n), .cartridge_present(cartridge_present),
        .power_good(power_good), .index_pulse(index_pulse), .ready_n(ready_n),
        .status_n(status_n), .motor_run(motor_run), .lamp_on(lamp_on));

    // Clock at 250 MHz.
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Index sensor: one pulse every ten cycles while the spindle turns.
    initial begin
        icnt = 0;
        forever begin
            @(posedge pclk);
            index_pulse <= spin_on && (icnt == 0);
            icnt = (icnt + 1) % 10;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One APB transfer; waits for pready, and only the watchdog ends a hung wait.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, drive_opts_pkg::ADDR_CONFIG, d, r, e);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check("read_data", r, exp);
        check("read_error", {31'h0, e}, {31'h0, experr});
    endtask

    // Outputs are registered one edge behind their cause; three edges is ample.
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask

    task automatic set_disk(input logic v);
        @(posedge pclk);
        cartridge_present <= v;
    endtask

    // Pull the cartridge while deselected, put it back, then select again.
    task automatic swap_disk();
        i_host.select(9);
        set_disk(1'b0);
        settle();
        set_disk(1'b1);
        i_host.select(0);
        settle();
    endtask

    task automatic t_reset();
        logic [31:0] r;
        logic e;
        check("reset_outs", {ready_n, status_n, motor_run, lamp_on}, 4'hc);
        rd_check(drive_opts_pkg::ADDR_CONFIG, 32'h0, 1'b0);
        rd_check(drive_opts_pkg::ADDR_STATUS, 32'h84, 1'b0);
        apb(1'b1, drive_opts_pkg::ADDR_STATUS, 32'hff, r, e);
        rd_check(drive_opts_pkg::ADDR_STATUS, 32'h84, 1'b0);
        rd_check(8'h08, 32'h0, 1'b1);
    endtask

    task automatic t_select();
        for (int c = 0; c < 4; c++) begin
            cfg(32'(c));
            rd_check(drive_opts_pkg::ADDR_CONFIG, 32'(c), 1'b0);
            for (int j = 0; j < 4; j++) begin
                i_host.select(j);
                settle();
                check("lamp_sel", {31'h0, lamp_on}, {31'h0, j == c});
            end
        end
        i_host.select(9);
    endtask

    task automatic t_motor();
        int trig[4] = '{1, 2, 3, 0};
        for (int s = 0; s < 4; s++) begin
            cfg(32'(s) << 2);
            i_host.motor(1'b1);
            settle();
            check("motor_req", {31'h0, motor_run}, {31'h0, s == 0});
            i_host.motor(1'b0);
            i_host.select(trig[s]);
            settle();
            check("motor_sel", {31'h0, motor_run}, {31'h0, s != 0});
            i_host.select(9);
            settle();
            check("motor_off", {31'h0, motor_run}, 32'h0);
        end
        cfg(32'h0);
    endtask

    task automatic t_ready();
        i_host.motor(1'b1);
        i_host.select(0);
        spin_on <= 1'b1;
        settle();
        check("ready_spinup", {31'h0, ready_n}, 32'h1);
        repeat (60) @(posedge pclk);
        #1;
        check("ready_run", {31'h0, ready_n}, 32'h0);
        @(posedge pclk);
        power_good <= 1'b0;
        settle();
        check("ready_nopower", {31'h0, ready_n}, 32'h1);
        @(posedge pclk);
        power_good <= 1'b1;
        settle();
        check("ready_power", {31'h0, ready_n}, 32'h0);
        set_disk(1'b0);
        settle();
        check("ready_nodisk", {31'h0, ready_n}, 32'h1);
        set_disk(1'b1);
        i_host.select(9);
        settle();
        check("ready_desel", {31'h0, ready_n}, 32'h1);
        spin_on <= 1'b0;
        repeat (40) @(posedge pclk);
        i_host.select(0);
        settle();
        check("ready_stopped", {31'h0, ready_n}, 32'h1);
        i_host.motor(1'b0);
    endtask

    task automatic t_change();
        cfg(32'h0);
        swap_disk();
        check("change_set", {31'h0, status_n}, 32'h0);
        repeat (10) @(posedge pclk);
        #1;
        check("change_hold", {31'h0, status_n}, 32'h0);
        i_host.pulse_reset();
        settle();
        check("change_rst", {31'h0, status_n}, 32'h1);
        cfg(32'h10);
        swap_disk();
        i_host.pulse_reset();
        settle();
        check("change_noreset", {31'h0, status_n}, 32'h0);
        i_host.pulse_step();
        settle();
        check("change_step", {31'h0, status_n}, 32'h1);
        cfg(32'h20);
        settle();
        check("present_in", {31'h0, status_n}, 32'h0);
        set_disk(1'b0);
        settle();
        check("present_out", {31'h0, status_n}, 32'h1);
        set_disk(1'b1);
    endtask

    task automatic t_lamp();
        cfg(32'h40);
        i_host.select(9);
        i_host.in_use(1'b1);
        settle();
        check("lamp_host_on", {31'h0, lamp_on}, 32'h1);
        i_host.select(0);
        i_host.in_use(1'b0);
        settle();
        check("lamp_host_off", {31'h0, lamp_on}, 32'h0);
    endtask

    // Watchdog: the sequence needs about 400 cycles.
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        num_errors = 0;
        checked = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        cartridge_present = 1'b1;
        power_good = 1'b1;
        index_pulse = 1'b0;
        spin_on = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        t_reset();
        t_select();
        t_motor();
        t_ready();
        t_change();
        t_lamp();
        print_verdict();
    end
endmodule

`default_nettype wire
